// ===== design/frame_pkg.sv
// Package with constants and carrier types for the serial frame handler.
package frame_pkg;
	// ***********************************************************
	// Timing.
	// ***********************************************************
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned BITS_PER_CHAR = 11;
	localparam int unsigned GAP_CHARS_X2 = 7;
	localparam int unsigned GAP_MARGIN_BITS = 1;
	// ***********************************************************
	// Baud and parity selection codes and addresses.
	// ***********************************************************
	localparam logic [2:0] BAUD_2400 = 3'h0;
	localparam logic [2:0] BAUD_9600 = 3'h1;
	localparam logic [2:0] BAUD_14400 = 3'h2;
	localparam logic [2:0] BAUD_28800 = 3'h3;
	localparam logic [2:0] BAUD_57600 = 3'h4;
	localparam logic [2:0] BAUD_115200 = 3'h5;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hc8;
	// ***********************************************************
	// Function codes, values and CRC constants.
	// ***********************************************************
	localparam logic [7:0] FC_READ_COILS = 8'h01;
	localparam logic [7:0] FC_READ_REGS = 8'h03;
	localparam logic [7:0] FC_FORCE_COIL = 8'h05;
	localparam logic [7:0] FC_PRESET_REGS = 8'h10;
	localparam logic [7:0] FC_EXC_BIT = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [7:0] MAX_COILS = 8'h10;
	localparam logic [7:0] MAX_REGS = 8'h20;
	localparam int unsigned BUF_BYTES = 73;
	localparam int unsigned FIFO_DEPTH = 16;
	// User-side request to the load.
	typedef struct packed {
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] data;
	} access_t;
endpackage

// ===== design/byte_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Synchronous reset, active low.
	input wire logic i_valid, // Write data valid.
	output logic o_ready, // Space available.
	input wire logic [WIDTH-1:0] i_data, // Write data.
	output logic o_valid, // Read data valid.
	input wire logic i_ready, // Reader takes data.
	output logic [WIDTH-1:0] o_data // Read data.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q, rd_q;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	// Full and empty come from pointers with a wrap bit.
	assign o_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign o_valid = (wr_q != rd_q);
	assign o_data = mem[rd_q[AW-1:0]];
	// Pointers advance on each accepted transfer.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
	// Storage array has no reset.
	always_ff @(posedge i_clk) begin
		if (push) mem[wr_q[AW-1:0]] <= i_data;
	end
endmodule

// ===== design/frame_handler.sv
// Serial slave frame handler: UART, gap framing, CRC, decode and reply.
`timescale 1ns/1ps
//
// Contract
// RULE_01: Frames are delimited by idle gaps over three and a half characters.
// RULE_02: Characters are one start, eight data, one stop bit.
// RULE_03: Parity is selectable none, odd or even.
// RULE_04: Baud is selectable 2400, 9600, 14400, 28800, 57600 or 115200.
// RULE_05: Only frames carrying our station address are answered.
// RULE_06: Station address is valid only from 1 to 200.
// RULE_07: Multi-byte data fields travel most significant byte first.
// RULE_08: Coil value ff00 sets on, 0000 off, others leave unchanged.
// RULE_09: Function codes 01, 05, 03 and 10 are decoded.
// RULE_10: Frames end in a CRC-16, low byte first.
// RULE_11: CRC presets to all ones; each byte is XORed into low bits.
// RULE_12: Eight right shifts per byte, XOR a001 when the LSB is one.
// RULE_13: Read-coils request holds start address and count 1 to 16.
// RULE_14: Read-coils reply holds byte count 1 or 2 and coil bits.
// RULE_15: First requested coil sits in bit zero of first byte.
// RULE_16: Exception reply sets the top bit of the function code.
// RULE_17: Exception code lies between 01 and 04.
// RULE_18: Force-coil reply echoes address, function, coil and value.
// RULE_19: Read-registers request holds start address and count 1 to 32.
// RULE_20: Read-registers reply holds byte count twice the count, then data.
// RULE_21: Preset request holds address, count 1 to 32, byte count, data.
// RULE_22: A failing preset request is answered with function 90.
// RULE_23: Frames with a bad CRC are dropped without any reply.
// RULE_24: Gap threshold is derived from baud at eleven bits per character.
module frame_handler (
	input wire logic i_clk, // System clock, 10 MHz.
	input wire logic i_rst_n, // Synchronous reset, active low.
	input wire logic i_rxd, // Serial receive line.
	output logic o_txd, // Serial transmit line.
	input wire logic [2:0] i_baud_sel, // Baud rate code.
	input wire logic [1:0] i_parity_sel, // Parity mode.
	input wire logic [7:0] i_station, // Station address.
	output logic o_acc_valid, // Load access request strobe.
	output frame_pkg::access_t o_acc, // Load access request.
	input wire logic [15:0] i_acc_rdata, // Read data for the request.
	input wire logic i_acc_ok // Address accepted by the load.
);
	// ***********************************************************
	// Baud timing.
	// ***********************************************************
	function automatic logic [15:0] bit_cycles(input logic [2:0] sel);
		unique case (sel)
			frame_pkg::BAUD_2400: bit_cycles = 16'(frame_pkg::CLK_HZ / 2400);
			frame_pkg::BAUD_9600: bit_cycles = 16'(frame_pkg::CLK_HZ / 9600);
			frame_pkg::BAUD_14400: bit_cycles = 16'(frame_pkg::CLK_HZ / 14400);
			frame_pkg::BAUD_28800: bit_cycles = 16'(frame_pkg::CLK_HZ / 28800);
			frame_pkg::BAUD_57600: bit_cycles = 16'(frame_pkg::CLK_HZ / 57600);
			default: bit_cycles = 16'(frame_pkg::CLK_HZ / 115200);
		endcase
	endfunction
	// CRC step over one byte, eight shifts.
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b}; // see RULE_11
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ frame_pkg::CRC_POLY) : (r >> 1); // see RULE_12
		end
		crc_byte = r;
	endfunction
	wire [15:0] bit_len = bit_cycles(i_baud_sel); // see RULE_04
	// Gap of 38 bit times (3.5 characters rounded down) plus a one-bit margin, in cycles.
	wire [31:0] gap_len = 32'(bit_len) * (frame_pkg::BITS_PER_CHAR * frame_pkg::GAP_CHARS_X2 / 2
		+ frame_pkg::GAP_MARGIN_BITS); // see RULE_24
	wire par_on = (i_parity_sel != frame_pkg::PAR_NONE);
	wire [3:0] nbits = par_on ? 4'd11 : 4'd10; // see RULE_02 RULE_03
	// ***********************************************************
	// Receiver.
	// ***********************************************************
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_idx_q;
	logic [9:0] rx_sh_q;
	logic rx_busy_q, rx_stb_q, rx_bad_q, rx_perr_q;
	logic [7:0] rx_byte_q;
	logic [31:0] idle_q;
	wire rx_last = rx_busy_q && rx_cnt_q == 16'h0000 && rx_idx_q == nbits - 4'd1;
	wire exp_par = ^rx_sh_q[8:1] ^ (i_parity_sel == frame_pkg::PAR_ODD);
	// Sample mid-bit, shift LSB first, check stop and parity.
	always_ff @(posedge i_clk) begin
		rx_stb_q <= 1'b0;
		if (!i_rst_n) begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= '0;
			rx_idx_q <= '0;
			rx_sh_q <= '0;
			rx_byte_q <= '0;
			rx_perr_q <= 1'b0;
		end else if (!rx_busy_q) begin
			if (!i_rxd) begin
				rx_busy_q <= 1'b1;
				rx_cnt_q <= bit_len >> 1;
				rx_idx_q <= '0;
			end
		end else if (rx_cnt_q != 16'h0000) begin
			rx_cnt_q <= rx_cnt_q - 16'h0001;
		end else begin
			rx_cnt_q <= bit_len - 16'h0001;
			rx_idx_q <= rx_idx_q + 4'd1;
			rx_sh_q <= {i_rxd, rx_sh_q[9:1]};
			if (rx_idx_q == 4'd0 && i_rxd) rx_busy_q <= 1'b0;
			if (rx_last) begin
				rx_busy_q <= 1'b0;
				rx_stb_q <= i_rxd; // see RULE_02
				rx_byte_q <= par_on ? rx_sh_q[8:1] : rx_sh_q[9:2];
				rx_perr_q <= par_on && (rx_sh_q[9] != exp_par); // see RULE_03
			end
		end
	end
	// Idle counter: a full gap closes the frame.
	wire gap_hit = (idle_q == gap_len);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) idle_q <= '0;
		else if (rx_busy_q || !i_rxd) idle_q <= '0;
		else if (idle_q != gap_len) idle_q <= idle_q + 32'd1; // see RULE_01
	end
	// ***********************************************************
	// Frame buffer and CRC.
	// ***********************************************************
	// Sequencer state, declared here because the buffer clears on it.
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ACC, S_HDR, S_SEND, S_CRC, S_CLR} state_t;
	state_t state_q;
	logic [7:0] buf_q [frame_pkg::BUF_BYTES];
	logic [6:0] len_q;
	logic [15:0] rcrc_q;
	wire [15:0] rcrc_next = crc_byte(rcrc_q, rx_byte_q);
	logic done_q;
	// Collect bytes, mark overflow or parity errors as bad.
	always_ff @(posedge i_clk) begin
		done_q <= 1'b0;
		if (!i_rst_n) begin
			len_q <= '0;
			rcrc_q <= frame_pkg::CRC_INIT;
			rx_bad_q <= 1'b0;
		end else if (gap_hit && len_q != 7'd0) begin
			done_q <= 1'b1;
		end else if (rx_stb_q) begin
			if (len_q < 7'(frame_pkg::BUF_BYTES)) begin
				buf_q[len_q] <= rx_byte_q;
				len_q <= len_q + 7'd1;
			end else rx_bad_q <= 1'b1;
			rcrc_q <= rcrc_next;
			if (rx_perr_q) rx_bad_q <= 1'b1;
		end
		if (i_rst_n && state_q == S_CLR) begin
			len_q <= '0;
			rcrc_q <= frame_pkg::CRC_INIT; // see RULE_11
			rx_bad_q <= 1'b0;
		end
	end
	// ***********************************************************
	// Decode.
	// ***********************************************************
	wire [7:0] fc = buf_q[1];
	wire [15:0] start = {buf_q[2], buf_q[3]}; // see RULE_07
	wire [15:0] qty = {buf_q[4], buf_q[5]};
	wire addr_ok = (buf_q[0] == i_station) && (i_station >= frame_pkg::ADDR_MIN)
		&& (i_station <= frame_pkg::ADDR_MAX); // see RULE_05 RULE_06
	// A good CRC over the whole frame including the check leaves zero.
	wire crc_ok = (rcrc_q == 16'h0000) && !rx_bad_q && len_q >= 7'd4; // see RULE_10 RULE_23
	wire fc_known = fc == frame_pkg::FC_READ_COILS || fc == frame_pkg::FC_READ_REGS
		|| fc == frame_pkg::FC_FORCE_COIL || fc == frame_pkg::FC_PRESET_REGS; // see RULE_09
	wire coil_val_ok = qty == frame_pkg::COIL_ON || qty == frame_pkg::COIL_OFF; // see RULE_08
	wire cnt_ok = (fc == frame_pkg::FC_READ_COILS) ? (qty >= 16'h0001 && qty <= 16'(frame_pkg::MAX_COILS))
		: (fc == frame_pkg::FC_FORCE_COIL) ? coil_val_ok
		: (fc == frame_pkg::FC_PRESET_REGS) ? (qty >= 16'h0001 && qty <= 16'(frame_pkg::MAX_REGS)
			&& buf_q[6] == 8'(qty << 1) && len_q == 7'(qty << 1) + 7'd9) // see RULE_21 RULE_22
		: (qty >= 16'h0001 && qty <= 16'(frame_pkg::MAX_REGS)); // see RULE_13 RULE_19
	// ***********************************************************
	// Sequencer: execute accesses, then send reply.
	// ***********************************************************
	logic [5:0] item_q;
	logic [15:0] coils_q, tcrc_q;
	logic [7:0] exc_q;
	logic [1:0] crc_phase_q;
	logic [7:0] tx_in;
	logic tx_in_v;
	wire tx_in_rdy;
	wire is_exc = (exc_q != 8'h00);
	wire is_read = (fc == frame_pkg::FC_READ_COILS) || (fc == frame_pkg::FC_READ_REGS);
	wire [5:0] n_items = (fc == frame_pkg::FC_FORCE_COIL) ? 6'd1 : 6'(qty);
	wire [7:0] coil_bytes = (qty > 16'h0008) ? 8'h02 : 8'h01; // see RULE_14
	// Header bytes: address, code, then count or echoed fields.
	wire [5:0] hdr_len = is_exc ? 6'd3 : is_read ? 6'd3 : 6'd6;
	wire [7:0] hdr_byte = (item_q == 6'd0) ? buf_q[0]
		: (item_q == 6'd1) ? (is_exc ? (fc | frame_pkg::FC_EXC_BIT) : fc) // see RULE_16 RULE_22
		: is_exc ? exc_q // see RULE_17
		: (fc == frame_pkg::FC_READ_COILS) ? coil_bytes
		: (fc == frame_pkg::FC_READ_REGS) ? 8'(qty << 1) // see RULE_20
		: buf_q[item_q]; // see RULE_18
	// Body bytes for reads: coil bytes, or register words high first.
	wire [7:0] body_byte = (fc == frame_pkg::FC_READ_COILS)
		? (item_q[0] ? coils_q[15:8] : coils_q[7:0]) // see RULE_15
		: (item_q[0] ? i_acc_rdata[7:0] : i_acc_rdata[15:8]); // see RULE_07
	wire [6:0] body_len = (fc == frame_pkg::FC_READ_COILS) ? 7'(coil_bytes) : 7'(qty << 1);
	assign o_acc.func = fc;
	// Register reads step one word for every two bytes sent.
	wire [5:0] acc_idx = (state_q == S_SEND) ? (item_q >> 1) : item_q;
	assign o_acc.addr = start + 16'(acc_idx);
	assign o_acc.data = (fc == frame_pkg::FC_FORCE_COIL) ? qty
		: {buf_q[7 + 2 * item_q], buf_q[8 + 2 * item_q]};
	assign o_acc_valid = (state_q == S_ACC) && (fc != frame_pkg::FC_READ_REGS);
	// Output byte multiplexer into the transmit FIFO.
	always_comb begin
		tx_in_v = 1'b0;
		tx_in = 8'h00;
		if (state_q == S_HDR) begin
			tx_in_v = 1'b1;
			tx_in = hdr_byte;
		end else if (state_q == S_SEND) begin
			tx_in_v = 1'b1;
			tx_in = body_byte;
		end else if (state_q == S_CRC) begin
			tx_in_v = 1'b1;
			tx_in = crc_phase_q[0] ? tcrc_q[15:8] : tcrc_q[7:0]; // see RULE_10
		end
	end
	wire take = tx_in_v && tx_in_rdy;
	// Main sequence control.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= S_IDLE;
			item_q <= '0;
			coils_q <= '0;
			exc_q <= '0;
			tcrc_q <= frame_pkg::CRC_INIT;
			crc_phase_q <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: if (done_q) state_q <= S_CHECK;
				S_CHECK: begin
					item_q <= '0;
					coils_q <= '0;
					tcrc_q <= frame_pkg::CRC_INIT;
					crc_phase_q <= '0;
					exc_q <= !fc_known ? frame_pkg::EXC_ILLEGAL_FUNC
						: !cnt_ok ? frame_pkg::EXC_ILLEGAL_VALUE : 8'h00;
					if (!crc_ok || !addr_ok) state_q <= S_CLR;
					else if (!fc_known || !cnt_ok || fc == frame_pkg::FC_READ_REGS) state_q <= S_HDR;
					else state_q <= S_ACC;
				end
				S_ACC: begin
					coils_q[item_q[3:0]] <= i_acc_rdata[0];
					if (!i_acc_ok) begin
						exc_q <= frame_pkg::EXC_ILLEGAL_VALUE - 8'h01;
						item_q <= '0;
						state_q <= S_HDR;
					end else if (item_q == n_items - 6'd1) begin
						item_q <= '0;
						state_q <= S_HDR;
					end else item_q <= item_q + 6'd1;
				end
				S_HDR: if (take) begin
					tcrc_q <= crc_byte(tcrc_q, tx_in);
					if (item_q == hdr_len - 6'd1) begin
						item_q <= '0;
						state_q <= (is_read && !is_exc) ? S_SEND : S_CRC;
					end else item_q <= item_q + 6'd1;
				end
				S_SEND: if (take) begin
					tcrc_q <= crc_byte(tcrc_q, tx_in);
					if ({1'b0, item_q} == body_len - 7'd1) state_q <= S_CRC; // see RULE_20
					else item_q <= item_q + 6'd1;
				end
				S_CRC: if (take) begin
					crc_phase_q <= crc_phase_q + 2'd1;
					if (crc_phase_q[0]) state_q <= S_CLR;
				end
				S_CLR: state_q <= S_IDLE;
			endcase
		end
	end
	// ***********************************************************
	// Transmit FIFO and serialiser.
	// ***********************************************************
	wire tx_f_v;
	wire [7:0] tx_f_d;
	logic tx_busy_q;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic [15:0] tx_cnt_q;
	wire tx_load = tx_f_v && !tx_busy_q;
	byte_fifo #(.WIDTH(8), .DEPTH(frame_pkg::FIFO_DEPTH)) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_valid(tx_in_v),
		.o_ready(tx_in_rdy),
		.i_data(tx_in),
		.o_valid(tx_f_v),
		.i_ready(tx_load),
		.o_data(tx_f_d)
	);
	wire tx_par = ^tx_f_d ^ (i_parity_sel == frame_pkg::PAR_ODD);
	// Shift out start, data LSB first, optional parity and stop.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx_busy_q <= 1'b0;
			tx_sh_q <= '1;
			tx_left_q <= '0;
			tx_cnt_q <= '0;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			tx_sh_q <= par_on ? {1'b1, tx_par, tx_f_d, 1'b0} : {2'b11, tx_f_d, 1'b0}; // see RULE_02
			tx_left_q <= nbits;
			tx_cnt_q <= bit_len - 16'h0001;
		end else if (tx_busy_q) begin
			if (tx_cnt_q != 16'h0000) tx_cnt_q <= tx_cnt_q - 16'h0001;
			else begin
				tx_cnt_q <= bit_len - 16'h0001;
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'd1;
				if (tx_left_q == 4'd1) tx_busy_q <= 1'b0;
			end
		end
	end
	assign o_txd = tx_busy_q ? tx_sh_q[0] : 1'b1;
endmodule

// ===== bench/host_model.sv
// Behavioural host master that sends request frames and collects replies.
`timescale 1ns/1ps
module host_model #(
	parameter int BIT = 86
) (
	input wire logic i_clk, // System clock.
	input wire logic [1:0] i_par, // Parity mode shared with the device.
	input wire logic i_line, // Device transmit line.
	output logic o_line // Host transmit line, idle high.
);
	int perr;
	// The line idles high until the first frame.
	initial begin
		o_line = 1'b1;
		perr = 0;
	end
	// Drives one bit for one bit time, starting just after a clock edge.
	task automatic put_bit(input logic v);
		o_line <= v;
		repeat (BIT) @(posedge i_clk);
	endtask
	// Sends each byte as start, data LSB first, optional parity, stop.
	task automatic send_frame(input logic [7:0] q[$]);
		foreach (q[i]) begin
			put_bit(1'b0);
			for (int k = 0; k < 8; k++) begin
				put_bit(q[i][k]);
			end
			if (i_par != 2'h0) begin
				put_bit(i_par == 2'h1 ? ~^q[i] : ^q[i]);
			end
			put_bit(1'b1);
		end
	endtask
	// Collects a reply; a silence of 45 bit times before the first byte, or 11 after it, ends the wait, which also
	// keeps well over three and a half characters between our frames.
	task automatic recv_frame(output logic [7:0] q[$]);
		int n;
		int lim;
		logic [7:0] b;
		q = {};
		lim = 45 * BIT;
		repeat (80) begin
			n = 0;
			while (i_line === 1'b1 && n < lim) begin
				@(posedge i_clk);
				n++;
			end
			if (n >= lim) break;
			repeat (BIT / 2) @(posedge i_clk);
			for (int k = 0; k < 8; k++) begin
				repeat (BIT) @(posedge i_clk);
				b[k] = i_line;
			end
			if (i_par != 2'h0) begin
				repeat (BIT) @(posedge i_clk);
				if (i_line !== (i_par == 2'h1 ? ~^b : ^b)) perr++;
			end
			repeat (BIT) @(posedge i_clk);
			if (i_line !== 1'b1) perr++;
			q.push_back(b);
			lim = 11 * BIT;
		end
	endtask
endmodule

// ===== bench/frame_handler_chk.sv
// Port-level assertions for the serial frame handler.
`timescale 1ns/1ps
module frame_handler_chk (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Synchronous reset, active low.
	input wire logic i_rxd, // Serial receive line.
	input wire logic o_txd, // Serial transmit line.
	input wire logic [2:0] i_baud_sel, // Baud rate code.
	input wire logic [1:0] i_parity_sel, // Parity mode.
	input wire logic [7:0] i_station, // Station address.
	input wire logic o_acc_valid, // Access strobe.
	input wire frame_pkg::access_t o_acc, // Access request.
	input wire logic [15:0] i_acc_rdata, // Access read data.
	input wire logic i_acc_ok // Access accepted.
);
	int idle_q;
	int gap_min;
	// Bit time in clock cycles for each rate code.
	function automatic int bit_cyc(input logic [2:0] sel);
		case (sel)
			3'h0: return frame_pkg::CLK_HZ / 2400;
			3'h1: return frame_pkg::CLK_HZ / 9600;
			3'h2: return frame_pkg::CLK_HZ / 14400;
			3'h3: return frame_pkg::CLK_HZ / 28800;
			3'h4: return frame_pkg::CLK_HZ / 57600;
			default: return frame_pkg::CLK_HZ / 115200;
		endcase
	endfunction
	// A frame only closes after more than three and a half characters of idle.
	assign gap_min = bit_cyc(i_baud_sel) * 77 / 2;
	// Counts idle cycles on the receive line, saturating.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_rxd) begin
			idle_q <= 0;
		end else if (idle_q < 1000000) begin
			idle_q <= idle_q + 1;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_pulse;
		o_acc_valid ##1 (!o_acc_valid || o_acc.addr == $past(o_acc.addr) + 16'h0001);
	endsequence
	sequence s_start_bit;
		!o_txd [*8];
	endsequence
	property p_reset_idle;
		$rose(i_rst_n) |-> o_txd && !o_acc_valid;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("line busy after reset");
	property p_start_len;
		$fell(o_txd) |=> s_start_bit;
	endproperty
	a_start_len: assert property (p_start_len) else $error("start bit too short");
	property p_reply_gap;
		$fell(o_txd) |-> idle_q > gap_min;
	endproperty
	a_reply_gap: assert property (p_reply_gap) else $error("reply before frame gap");
	property p_acc_gap;
		$rose(o_acc_valid) |-> idle_q > gap_min;
	endproperty
	a_acc_gap: assert property (p_acc_gap) else $error("access before frame gap");
	property p_acc_pulse;
		o_acc_valid |-> s_pulse;
	endproperty
	a_acc_pulse: assert property (p_acc_pulse) else $error("access items out of order");
	property p_acc_func;
		o_acc_valid |-> o_acc.func == frame_pkg::FC_READ_COILS ||
			o_acc.func == frame_pkg::FC_FORCE_COIL || o_acc.func == frame_pkg::FC_PRESET_REGS;
	endproperty
	a_acc_func: assert property (p_acc_func) else $error("access with bad function");
	property p_station;
		(i_station == 8'h00 || i_station > frame_pkg::ADDR_MAX) |-> !o_acc_valid && o_txd;
	endproperty
	a_station: assert property (p_station) else $error("answer with bad station");
	property p_force_value;
		o_acc_valid && o_acc.func == frame_pkg::FC_FORCE_COIL |->
			o_acc.data == frame_pkg::COIL_ON || o_acc.data == frame_pkg::COIL_OFF;
	endproperty
	a_force_value: assert property (p_force_value) else $error("coil forced by bad value");
endmodule
bind frame_handler frame_handler_chk frame_handler_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_rxd(i_rxd), .o_txd(o_txd), .i_baud_sel(i_baud_sel), .i_parity_sel(i_parity_sel),
	.i_station(i_station), .o_acc_valid(o_acc_valid), .o_acc(o_acc),
	.i_acc_rdata(i_acc_rdata), .i_acc_ok(i_acc_ok));

// ===== bench/frame_handler_tb_top.sv
// Self-checking testbench for the serial frame handler.
`timescale 1ns/1ps
module frame_handler_tb_top;
	logic clk;
	logic rst_n;
	logic rxd;
	logic txd;
	logic [2:0] baud;
	logic [1:0] par;
	logic [7:0] station;
	logic acc_valid;
	frame_pkg::access_t acc;
	frame_pkg::access_t acc_seen;
	logic [15:0] rdata;
	logic acc_ok;
	int error_cnt;
	int checks;
	int acc_n;
	logic [7:0] req[$];
	logic [7:0] exp_q[$];
	// ***********************************************************
	// Clock, design and host.
	// ***********************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	frame_handler frame_handler_i (.i_clk(clk), .i_rst_n(rst_n), .i_rxd(rxd), .o_txd(txd),
		.i_baud_sel(baud), .i_parity_sel(par), .i_station(station), .o_acc_valid(acc_valid),
		.o_acc(acc), .i_acc_rdata(rdata), .i_acc_ok(acc_ok));
	host_model #(.BIT(frame_pkg::CLK_HZ / 115200)) host_model_i (.i_clk(clk), .i_par(par),
		.i_line(txd), .o_line(rxd));
	// Records every load access strobe.
	always @(posedge clk) begin
		if (acc_valid === 1'b1) begin
			acc_seen <= acc;
			acc_n <= acc_n + 1;
		end
	end
	// ***********************************************************
	// Helpers.
	// ***********************************************************
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = frame_pkg::CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) begin
				c = c[0] ? (c >> 1) ^ frame_pkg::CRC_POLY : c >> 1;
			end
		end
		return c;
	endfunction
	// Appends the check word, low byte first.
	task automatic add_crc(inout logic [7:0] q[$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endtask
	// Sends the request and compares the reply with exp_q and its check word.
	task automatic run();
		logic [7:0] got[$];
		if (exp_q.size() > 0) add_crc(exp_q);
		host_model_i.send_frame(req);
		host_model_i.recv_frame(got);
		check(got.size(), exp_q.size());
		foreach (exp_q[i]) check(got[i], exp_q[i]);
		check(host_model_i.perr, 0);
	endtask
	task automatic setup(input logic [1:0] p, input logic [7:0] s, input logic [15:0] d);
		@(posedge clk);
		par <= p;
		station <= s;
		rdata <= d;
		@(posedge clk);
	endtask
	// ***********************************************************
	// Scenarios.
	// ***********************************************************
	// One coil read with even parity; the coil lands in bit zero.
	task automatic test_read_coil();
		int n0;
		n0 = acc_n;
		setup(frame_pkg::PAR_EVEN, 8'h01, 16'h0001);
		req = '{8'h01, 8'h01, 8'h05, 8'h10, 8'h00, 8'h01};
		add_crc(req);
		exp_q = '{8'h01, 8'h01, 8'h01, 8'h01};
		run();
		check(acc_n - n0, 1);
		check(acc_seen.addr, 16'h0510);
		$display("test read_coil done");
	endtask
	// A coil forced on with odd parity is echoed whole.
	task automatic test_force_coil();
		int n0;
		n0 = acc_n;
		setup(frame_pkg::PAR_ODD, 8'h01, 16'h0000);
		req = '{8'h01, 8'h05, 8'h05, 8'h00, 8'hff, 8'h00};
		exp_q = req;
		add_crc(req);
		run();
		check(acc_n - n0, 1);
		check(acc_seen, {frame_pkg::FC_FORCE_COIL, 16'h0500, frame_pkg::COIL_ON});
		$display("test force_coil done");
	endtask
	// One holding register is returned high byte first.
	task automatic test_read_regs();
		setup(frame_pkg::PAR_NONE, 8'h01, 16'h4120);
		req = '{8'h01, 8'h03, 8'h0b, 8'h00, 8'h00, 8'h01};
		add_crc(req);
		exp_q = '{8'h01, 8'h03, 8'h02, 8'h41, 8'h20};
		run();
		$display("test read_regs done");
	endtask
	// Two registers are preset and echoed; a refused address gives code 02.
	task automatic test_preset();
		int n0;
		setup(frame_pkg::PAR_NONE, 8'h01, 16'h0000);
		n0 = acc_n;
		req = '{8'h01, 8'h10, 8'h0a, 8'h01, 8'h00, 8'h02, 8'h04, 8'h40, 8'h13, 8'h33, 8'h33};
		exp_q = req[0:5];
		add_crc(req);
		run();
		check(acc_n - n0, 2);
		check(acc_seen, {frame_pkg::FC_PRESET_REGS, 16'h0a02, 16'h3333});
		acc_ok <= 1'b0;
		exp_q = '{8'h01, 8'h90, 8'h02};
		run();
		acc_ok <= 1'b1;
		$display("test preset done");
	endtask
	// Another station's frame and a corrupted frame bring no reply.
	task automatic test_silence();
		int n0;
		n0 = acc_n;
		setup(frame_pkg::PAR_NONE, 8'h01, 16'h0001);
		req = '{8'h02, 8'h01, 8'h05, 8'h10, 8'h00, 8'h01};
		add_crc(req);
		exp_q = {};
		run();
		setup(frame_pkg::PAR_NONE, 8'hc9, 16'h0001);
		req = '{8'hc9, 8'h01, 8'h05, 8'h10, 8'h00, 8'h01};
		add_crc(req);
		run();
		setup(frame_pkg::PAR_NONE, 8'h01, 16'h0001);
		req = '{8'h01, 8'h01, 8'h05, 8'h10, 8'h00, 8'h01};
		add_crc(req);
		req[7] = req[7] ^ 8'h01;
		run();
		check(acc_n - n0, 0);
		$display("test silence done");
	endtask
	// Bad counts, a bad coil value and an unknown code give exception replies.
	task automatic test_exceptions();
		logic [7:0] fc[5] = '{8'h01, 8'h05, 8'h03, 8'h10, 8'h04};
		logic [15:0] val[5] = '{16'h0011, 16'h1234, 16'h0021, 16'h0000, 16'h0001};
		logic [7:0] cd[5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
		int n0;
		setup(frame_pkg::PAR_NONE, 8'h01, 16'h0000);
		n0 = acc_n;
		for (int i = 0; i < 5; i++) begin
			req = '{8'h01, fc[i], 8'h00, 8'h00, val[i][15:8], val[i][7:0]};
			if (fc[i] == frame_pkg::FC_PRESET_REGS) req.push_back(8'h00);
			add_crc(req);
			exp_q = '{8'h01, fc[i] | 8'h80, cd[i]};
			run();
		end
		check(acc_n - n0, 0);
		$display("test exceptions done");
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence after two cycles of reset.
	initial begin
		rst_n = 1'b0;
		baud = frame_pkg::BAUD_115200;
		par = 2'h0;
		station = 8'h01;
		rdata = 16'h0000;
		acc_ok = 1'b1;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		test_read_coil();
		test_force_coil();
		test_read_regs();
		test_preset();
		test_silence();
		test_exceptions();
		finish_test();
	end
	// Cuts a hang short.
	initial begin
		repeat (400000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule
